// ---- logic/ushft_bit_tick.v ----
// Bit-time tick divider from the system clock
`timescale 1ns/1ps
`include "ushft_consts.vh"
module ushft_bit_tick #(
  parameter [7:0] DIV = `USHFT_BITTIME_DIV
) (
  input  wire clk_sys_i,
  input  wire rstn_i,
  output wire tick_o
);
  reg [7:0] cnt_reg;
  wire [7:0] cnt_next;
  // 250 MHz / 12 MHz is not whole; DIV stays a parameter so a board can trim it
  assign cnt_next = (cnt_reg == DIV - `USHFT_CNT_ONE) ? `USHFT_CNT_ZERO : cnt_reg + `USHFT_CNT_ONE;
  assign tick_o   = (cnt_reg == DIV - `USHFT_CNT_ONE);
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cnt_reg <= `USHFT_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ---- logic/ushft_consts.vh ----
// Constants for the host frame timer: command codes, field positions, reset values
`ifndef USHFT_CONSTS_VH
`define USHFT_CONSTS_VH
`define USHFT_CMD_IVL_RD      8'h0D
`define USHFT_CMD_IVL_WR      8'h8D
`define USHFT_CMD_REM_RD      8'h0E
`define USHFT_CMD_REM_WR      8'h8E
`define USHFT_CMD_NUM_RD      8'h0F
`define USHFT_CMD_NUM_WR      8'h8F
`define USHFT_IVL_NOMINAL     14'h2EDF
`define USHFT_IVL_LSB         0
`define USHFT_IVL_MSB         13
`define USHFT_PKT_LSB         16
`define USHFT_PKT_MSB         30
`define USHFT_TOG_BIT         31
`define USHFT_REM_ZERO        14'h0000
`define USHFT_PKT_ZERO        15'h0000
`define USHFT_NUM_ZERO        16'h0000
`define USHFT_NUM_ONE         16'h0001
`define USHFT_REM_ONE         14'h0001
`define USHFT_WORD_ZERO       32'h00000000
`define USHFT_BITTIME_DIV     8'h14
`define USHFT_CNT_ONE         8'h01
`define USHFT_CNT_ZERO        8'h00
`endif

// ---- logic/ushft_frame_timer.v ----
// Frame timing unit of a full-speed host controller
// Functional notes
// - Hold 14-bit frame interval, nominal 11999, giving 12000 bit times between start-of-frames.
// - Controller reset command returns frame interval to nominal.
// - Load 15-bit largest-packet field into packet counter at each frame start.
// - Frame remaining counter decrements once per bit time.
// - At zero, remaining counter reloads from interval at next bit time.
// - At zero, interval toggle copies into remaining toggle bit 31.
// - Entering operational state reloads remaining counter from interval.
// - Frame number increments at each reload, wrapping FFFF to 0.
// - Frame number increments on entering operational state.
// - After increment and start-of-frame, write frame number to shared area first.
// - After that shared area write, set start-of-frame status flag.
// - Remaining register read code 0E, write code 8E.
// - Frame number read code 0F, write 8F; field read-only, resets zero.
// - Interval register read code 0D, write code 8D.
`timescale 1ns/1ps
`include "ushft_consts.vh"
module ushft_frame_timer #(
  parameter [7:0] BIT_DIV = `USHFT_BITTIME_DIV
) (
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  input  wire        cmd_valid_i,
  input  wire [7:0]  cmd_code_i,
  input  wire [31:0] cmd_wdata_i,
  output wire        cmd_ready_o,
  output reg  [31:0] cmd_rdata_o,
  output reg         cmd_rvalid_o,
  input  wire        controller_reset_cmd_i,
  input  wire        operational_state_i,
  input  wire        xfer_bit_i,
  input  wire        xfer_req_i,
  input  wire [14:0] xfer_size_i,
  output wire        xfer_grant_o,
  output reg         sof_o,
  output reg         shared_comm_area_wr_o,
  output reg  [15:0] shared_comm_area_data_o,
  input  wire        shared_comm_area_ack_i,
  output wire        ed_fetch_ok_o,
  output reg         sof_status_flag_o,
  input  wire        sof_status_clr_i,
  output wire [13:0] frame_remaining_o,
  output wire [15:0] frame_number_o
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SHARED_COMM_AREA = 2'b01;
  localparam [1:0] ST_FLAG = 2'b10;

  reg  [13:0] frame_interval_reg;
  reg  [14:0] largest_packet_bits_reg;
  reg         interval_toggle_reg;
  reg  [13:0] frame_remaining_reg;
  reg         remaining_toggle_reg;
  reg  [15:0] frame_number_reg;
  reg  [14:0] pkt_cnt_reg;
  reg         reload_pend_reg;
  reg         oper_d_reg;
  reg  [1:0]  st_reg;
  reg  [1:0]  st_next;
  wire        bit_tick;
  wire        oper_rise;
  wire        frame_start;
  wire        wr_ivl;
  wire        wr_rem;

  ushft_bit_tick #(
    .DIV(BIT_DIV)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rstn_i   (rstn_i),
    .tick_o   (bit_tick)
  );

  assign cmd_ready_o       = 1'b1;
  assign wr_ivl            = cmd_valid_i && (cmd_code_i == `USHFT_CMD_IVL_WR);
  assign wr_rem            = cmd_valid_i && (cmd_code_i == `USHFT_CMD_REM_WR);
  assign oper_rise         = operational_state_i && !oper_d_reg;
  // Reload happens one bit time after zero is seen, or on operational entry
  assign frame_start       = oper_rise || (bit_tick && reload_pend_reg);
  assign frame_remaining_o = frame_remaining_reg;
  assign frame_number_o    = frame_number_reg;
  assign xfer_grant_o      = xfer_req_i && (xfer_size_i <= pkt_cnt_reg);
  // Descriptor fetch is held off until the frame number has reached the shared area
  assign ed_fetch_ok_o     = (st_reg == ST_IDLE) && !frame_start;

  // Interval register; controller reset wins over a same-cycle write
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      frame_interval_reg      <= `USHFT_IVL_NOMINAL;
      largest_packet_bits_reg <= `USHFT_PKT_ZERO;
      interval_toggle_reg     <= 1'b0;
    end else if (controller_reset_cmd_i) begin
      frame_interval_reg      <= `USHFT_IVL_NOMINAL;
    end else if (wr_ivl) begin
      frame_interval_reg      <= cmd_wdata_i[`USHFT_IVL_MSB:`USHFT_IVL_LSB];
      largest_packet_bits_reg <= cmd_wdata_i[`USHFT_PKT_MSB:`USHFT_PKT_LSB];
      interval_toggle_reg     <= cmd_wdata_i[`USHFT_TOG_BIT];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      oper_d_reg <= 1'b0;
    end else begin
      oper_d_reg <= operational_state_i;
    end
  end

  // Frame remaining counter, toggle and frame number
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      frame_remaining_reg  <= `USHFT_REM_ZERO;
      remaining_toggle_reg <= 1'b0;
      frame_number_reg     <= `USHFT_NUM_ZERO;
      reload_pend_reg      <= 1'b0;
    end else if (frame_start) begin
      frame_remaining_reg  <= frame_interval_reg;
      frame_number_reg     <= frame_number_reg + `USHFT_NUM_ONE;
      reload_pend_reg      <= 1'b0;
    end else if (wr_rem) begin
      frame_remaining_reg  <= cmd_wdata_i[`USHFT_IVL_MSB:`USHFT_IVL_LSB];
      remaining_toggle_reg <= cmd_wdata_i[`USHFT_TOG_BIT];
    end else if (operational_state_i && bit_tick && !reload_pend_reg) begin
      if (frame_remaining_reg == `USHFT_REM_ZERO) begin
        reload_pend_reg      <= 1'b1;
        remaining_toggle_reg <= interval_toggle_reg;
      end else if (frame_remaining_reg == `USHFT_REM_ONE) begin
        frame_remaining_reg  <= `USHFT_REM_ZERO;
        remaining_toggle_reg <= interval_toggle_reg;
        reload_pend_reg      <= 1'b1;
      end else begin
        frame_remaining_reg  <= frame_remaining_reg - `USHFT_REM_ONE;
      end
    end
  end

  // Largest data packet counter
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pkt_cnt_reg <= `USHFT_PKT_ZERO;
    end else if (frame_start) begin
      pkt_cnt_reg <= largest_packet_bits_reg;
    end else if (xfer_bit_i && (pkt_cnt_reg != `USHFT_PKT_ZERO)) begin
      pkt_cnt_reg <= pkt_cnt_reg - 15'h0001;
    end
  end

  // Frame boundary sequence: SOF, shared area write, then status flag
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (frame_start) begin
          st_next = ST_SHARED_COMM_AREA;
        end
      end
      ST_SHARED_COMM_AREA: begin
        if (shared_comm_area_ack_i) begin
          st_next = ST_FLAG;
        end
      end
      ST_FLAG: begin
        st_next = ST_IDLE;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_reg                  <= ST_IDLE;
      sof_o                   <= 1'b0;
      shared_comm_area_wr_o   <= 1'b0;
      shared_comm_area_data_o <= `USHFT_NUM_ZERO;
    end else begin
      st_reg                  <= st_next;
      sof_o                   <= frame_start;
      shared_comm_area_wr_o   <= (st_next == ST_SHARED_COMM_AREA);
      if (st_reg == ST_IDLE && frame_start) begin
        shared_comm_area_data_o <= frame_number_reg + `USHFT_NUM_ONE;
      end
    end
  end

  // Set wins over a clear arriving in the same cycle
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sof_status_flag_o <= 1'b0;
    end else if (st_reg == ST_FLAG) begin
      sof_status_flag_o <= 1'b1;
    end else if (sof_status_clr_i) begin
      sof_status_flag_o <= 1'b0;
    end
  end

  // Coded reads; write codes and unknown codes return zero data
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cmd_rdata_o  <= `USHFT_WORD_ZERO;
      cmd_rvalid_o <= 1'b0;
    end else begin
      cmd_rvalid_o <= cmd_valid_i;
      case (cmd_code_i)
        `USHFT_CMD_IVL_RD: begin
          cmd_rdata_o <= {interval_toggle_reg, largest_packet_bits_reg, 2'b00, frame_interval_reg};
        end
        `USHFT_CMD_REM_RD: begin
          cmd_rdata_o <= {remaining_toggle_reg, 17'h00000, frame_remaining_reg};
        end
        `USHFT_CMD_NUM_RD: begin
          cmd_rdata_o <= {16'h0000, frame_number_reg};
        end
        default: begin
          cmd_rdata_o <= `USHFT_WORD_ZERO;
        end
      endcase
    end
  end
endmodule

// ---- tb/ushft_frame_timer_tb_top.sv ----
// Self-checking bench for the frame timer
`timescale 1ns/1ps
module ushft_frame_timer_tb_top;
  reg         clk_sys_i = 1'b0;
  reg         rstn_i = 1'b0;
  reg         cmd_valid_i = 1'b0;
  reg  [7:0]  cmd_code_i = 8'h00;
  reg  [31:0] cmd_wdata_i = 32'h00000000;
  reg         crst = 1'b0, opst = 1'b0, xbit = 1'b0, xreq = 1'b0, sclr = 1'b0;
  reg  [14:0] xsize = 15'h0000;
  reg  [3:0]  dly = 4'h0;
  reg  [31:0] rd, sv;
  integer     n_fail = 0, cmp_count = 0, cyc = 0, k;
  wire        rvld, grant, scw, sca, sflag;
  wire [31:0] rdata;
  wire [15:0] scd, fnum, mem;
  ushft_frame_timer #(.BIT_DIV(8'h02)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(),
    .cmd_rdata_o(rdata), .cmd_rvalid_o(rvld), .controller_reset_cmd_i(crst), .operational_state_i(opst),
    .xfer_bit_i(xbit), .xfer_req_i(xreq), .xfer_size_i(xsize), .xfer_grant_o(grant), .sof_o(),
    .shared_comm_area_wr_o(scw), .shared_comm_area_data_o(scd), .shared_comm_area_ack_i(sca),
    .ed_fetch_ok_o(), .sof_status_flag_o(sflag), .sof_status_clr_i(sclr), .frame_remaining_o(),
    .frame_number_o(fnum));
  ushft_host_mem hm (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wr_i(scw), .data_i(scd), .dly_i(dly),
    .ack_o(sca), .mem_o(mem));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task cmd(input [7:0] c, input [31:0] w);
    begin
      @(posedge clk_sys_i);
      cmd_valid_i <= 1'b1;
      cmd_code_i  <= c;
      cmd_wdata_i <= w;
      @(posedge clk_sys_i);
      cmd_valid_i <= 1'b0;
      #1 chk("rvalid", 32'h00000001, {31'h00000000, rvld});
      rd = rdata;
    end
  endtask
  task wait_fn;
    reg [15:0] f;
    begin
      f = fnum;
      k = 0;
      while (fnum === f && k < 200) begin
        @(posedge clk_sys_i);
        #1 k = k + 1;
      end
    end
  endtask
  task close_out;
    begin
      if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task t_regs;
    begin
      cmd(8'h0D, 0); chk("ivl rst", 32'h00002EDF, rd);
      cmd(8'h0E, 0); chk("rem rst", 0, rd);
      cmd(8'h10, 0); chk("unmapped", 0, rd);
      cmd(8'h8D, 32'h80050010); cmd(8'h0D, 0); chk("ivl wr", 32'h80050010, rd);
      cmd(8'h8F, 32'h00001234); cmd(8'h0F, 0); chk("num ro", 0, rd);
      cmd(8'h0D, 0); sv = rd;
      @(posedge clk_sys_i) crst <= 1'b1;
      @(posedge clk_sys_i) crst <= 1'b0;
      cmd(8'h0D, 0); chk("ivl nom", 32'h2EDF, {18'h00000, rd[13:0]});
      cmd(8'h8D, sv); cmd(8'h0D, 0); chk("ivl back", sv, rd);
    end
  endtask
  task t_frames(input [3:0] d);
    begin
      dly <= d;
      @(posedge clk_sys_i) sclr <= 1'b1;
      @(posedge clk_sys_i) sclr <= 1'b0;
      #1 chk("flag clr", 0, {31'h00000000, sflag});
      wait_fn; wait_fn; chk("period", 32'h00000022, k);
      @(posedge clk_sys_i) begin xreq <= 1'b1; xsize <= 15'h0005; end
      #1 chk("pkt load", 1, {31'h00000000, grant});
      @(posedge clk_sys_i) xbit <= 1'b1;
      @(posedge clk_sys_i) xbit <= 1'b0;
      #1 chk("pkt used", 0, {31'h00000000, grant});
      @(posedge clk_sys_i) xsize <= 15'h0004;
      #1 chk("pkt left", 1, {31'h00000000, grant});
      xreq <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      #1 chk("shared", {16'h0000, fnum}, {16'h0000, mem});
      chk("flag set", 1, {31'h00000000, sflag});
      cmd(8'h0E, 0); chk("rem tog", 1, {31'h00000000, rd[31]});
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    cmd(8'h0F, 0); chk("num rst", 0, rd);
    t_regs;
    @(posedge clk_sys_i) opst <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 chk("num op", 1, {16'h0000, fnum});
    t_frames(4'h0);
    t_frames(4'h6);
    close_out;
  end
endmodule
bind ushft_frame_timer ushft_ft_props chk_i (.clk_sys_i, .rstn_i, .cmd_valid_i, .cmd_code_i, .cmd_rdata_o,
  .cmd_rvalid_o, .operational_state_i, .sof_o, .shared_comm_area_wr_o, .shared_comm_area_data_o,
  .shared_comm_area_ack_i, .ed_fetch_ok_o, .sof_status_flag_o, .frame_remaining_o, .frame_number_o);

// ---- tb/ushft_ft_props.sv ----
// Port checker for the frame timer
`timescale 1ns/1ps
module ushft_ft_props (
  input wire        clk_sys_i,
  input wire        rstn_i,
  input wire        cmd_valid_i,
  input wire [7:0]  cmd_code_i,
  input wire [31:0] cmd_rdata_o,
  input wire        cmd_rvalid_o,
  input wire        operational_state_i,
  input wire        sof_o,
  input wire        shared_comm_area_wr_o,
  input wire [15:0] shared_comm_area_data_o,
  input wire        shared_comm_area_ack_i,
  input wire        ed_fetch_ok_o,
  input wire        sof_status_flag_o,
  input wire [13:0] frame_remaining_o,
  input wire [15:0] frame_number_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_rvalid_follows: assert property (cmd_valid_i |=> cmd_rvalid_o)
    else $error("read answer missing");
  a_num_read: assert property ((cmd_valid_i && cmd_code_i == 8'h0F) |=>
    cmd_rdata_o == {16'h0000, $past(frame_number_o)}) else $error("number read wrong");
  a_rem_read: assert property ((cmd_valid_i && cmd_code_i == 8'h0E) |=>
    cmd_rdata_o[13:0] == $past(frame_remaining_o)) else $error("remaining read wrong");
  a_num_step: assert property ($changed(frame_number_o) |->
    frame_number_o == $past(frame_number_o) + 16'h0001) else $error("number step wrong");
  a_sof_number: assert property ($changed(frame_number_o) |-> sof_o && shared_comm_area_wr_o &&
    shared_comm_area_data_o == frame_number_o) else $error("shared write missing");
  a_wr_held: assert property ((shared_comm_area_wr_o && !shared_comm_area_ack_i) |=>
    shared_comm_area_wr_o) else $error("shared write dropped");
  a_flag_set: assert property ((shared_comm_area_wr_o && shared_comm_area_ack_i) |=> ##1
    sof_status_flag_o) else $error("status flag late");
  a_fetch_block: assert property (shared_comm_area_wr_o |-> !ed_fetch_ok_o)
    else $error("fetch before write");
  a_op_start: assert property ($rose(operational_state_i) |-> ##[1:3] $changed(frame_number_o))
    else $error("no frame on start");
endmodule

// ---- tb/ushft_host_mem.sv ----
// Shared communication area model that answers frame number writes
`timescale 1ns/1ps
module ushft_host_mem (
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  input  wire        wr_i,
  input  wire [15:0] data_i,
  input  wire [3:0]  dly_i,
  output reg         ack_o,
  output reg  [15:0] mem_o
);
  reg [3:0] cnt_reg;
  // Slow answers stretch the time descriptor fetch must stay blocked
  always @(posedge clk_sys_i) begin
    if (!rstn_i || !wr_i || ack_o) begin
      cnt_reg <= 4'h0;
      ack_o   <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg >= dly_i) begin
        ack_o <= 1'b1;
        mem_o <= data_i;
      end
    end
  end
endmodule
